// ==== dv/uad_host_model.sv ====
/*
  Behavioural model of the bus side: the host and serial engine as the
  core sees them, reduced to one-cycle link pulses on ref_clk.
  Assumes the bench calls send() and that ref_clk runs freely.
*/
`timescale 1ns/1ps
module uad_host_model
(
  input wire logic ref_clk,
  output logic halt_event,
  output logic short_event,
  output logic rx_stored_ok,
  output logic tx_sent_ok,
  output logic bus_err,
  output logic txn_ok,
  output logic tx_no_ack,
  output logic ep0_in_token,
  output logic ep0_out_token,
  output logic ep0_setup_token,
  output logic ep0_in_sent,
  output logic ep0_stall_sent,
  output logic ep0_host_ack
);
  localparam int P_HALT = 0;
  localparam int P_SHORT = 1;
  localparam int P_RXOK = 2;
  localparam int P_TXOK = 3;
  localparam int P_ERR = 4;
  localparam int P_OK = 5;
  localparam int P_NOACK = 6;
  localparam int P_IN = 7;
  localparam int P_OUT = 8;
  localparam int P_SETUP = 9;
  localparam int P_SENT = 10;
  localparam int P_STALL = 11;
  logic [11:0] ev = 12'h000;
  logic ack_lvl = 1'b0;

  // One pulse per call, launched and dropped on falling edges
  task automatic send(input int k, input logic ack);
    @(negedge ref_clk);
    ev[k] = 1'b1;
    ack_lvl = ack;
    @(negedge ref_clk);
    ev = 12'h000;
    // Qualifier no longer valid: show the inverse, never a stale value
    ack_lvl = ~ack;
  endtask

  // Pulse fan-out
  assign halt_event = ev[P_HALT];
  assign short_event = ev[P_SHORT];
  assign rx_stored_ok = ev[P_RXOK];
  assign tx_sent_ok = ev[P_TXOK];
  assign bus_err = ev[P_ERR];
  assign txn_ok = ev[P_OK];
  assign tx_no_ack = ev[P_NOACK];
  assign ep0_in_token = ev[P_IN];
  assign ep0_out_token = ev[P_OUT];
  assign ep0_setup_token = ev[P_SETUP];
  assign ep0_in_sent = ev[P_SENT];
  assign ep0_stall_sent = ev[P_STALL];
  assign ep0_host_ack = ack_lvl;
endmodule

// ==== dv/usb_auto_dma_endpoint0_tb_top.sv ====
/*
  Self-checking bench for uad_core with the host model on its link side.
  Assumes uad_pkg is compiled first; inputs change on falling edges.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[ERR] %0t got %h expected %h", $time, got, exp); \
    end \
  end
module usb_auto_dma_endpoint0_tb_top;
  import uad_pkg::*;
  int fails = 0;
  int samples_checked = 0;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic auto_active = 1'b0;
  // Reserved select at start keeps the copy at its reset value
  logic [2:0] ep_select = 3'h6;
  logic dir_rx = 1'b0;
  logic iso_mode = 1'b0;
  logic [47:0] ep_status = 48'ha6a5_a4a3_a2a1;
  logic ep0_tx_fifo_en = 1'b0;
  logic ep0_rx_fifo_en = 1'b0;
  logic [3:0] ep0_free_bytes = 4'h8;
  logic halt_event, short_event, rx_stored_ok, tx_sent_ok, bus_err;
  logic txn_ok, tx_no_ack, ep0_in_token, ep0_out_token, ep0_setup_token;
  logic ep0_in_sent, ep0_stall_sent, ep0_host_ack;
  logic summary_set, count_exhausted_event, transfer_fault_event;
  logic tx_reload, rx_flush, iso_discard, ep0_stall_reply;
  logic ep0_rx_last_set, use_default_addr;

  // 25 MHz reference clock
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  uad_core DUT (
    .ref_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .auto_active, .ep_select, .dir_rx, .iso_mode, .ep_status,
    .halt_event, .short_event, .rx_stored_ok, .tx_sent_ok, .bus_err,
    .txn_ok, .tx_no_ack, .ep0_in_token, .ep0_out_token, .ep0_setup_token,
    .ep0_tx_fifo_en, .ep0_rx_fifo_en, .ep0_in_sent, .ep0_stall_sent,
    .ep0_host_ack, .ep0_free_bytes, .summary_set, .count_exhausted_event,
    .transfer_fault_event, .tx_reload, .rx_flush, .iso_discard,
    .ep0_stall_reply, .ep0_rx_last_set, .use_default_addr
  );

  uad_host_model host (
    .ref_clk, .halt_event, .short_event, .rx_stored_ok, .tx_sent_ok,
    .bus_err, .txn_ok, .tx_no_ack, .ep0_in_token, .ep0_out_token,
    .ep0_setup_token, .ep0_in_sent, .ep0_stall_sent, .ep0_host_ack
  );

  // Register write: strobe held for exactly one taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  // Register read; data is settled by the following falling edge
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
  endtask

  task automatic t_reset;
    rd_chk(UAD_IDX_EVENT_MASK, 8'h00);
    rd_chk(UAD_IDX_CHAN_COPY, 8'h1f);
    rd_chk(UAD_IDX_BUDGET, 8'h00);
    rd_chk(UAD_IDX_RETRY, 8'h00);
    rd_chk(UAD_IDX_EP0_CFG, 8'h00);
    rd_chk(UAD_IDX_EP0_TXS, 8'h08);
    // Unmapped index reads as zero
    rd_chk(3'h6, 8'h00);
  endtask

  task automatic t_mask;
    wr(UAD_IDX_EVENT_MASK, 8'hff);
    rd_chk(UAD_IDX_EVENT_MASK, 8'h0f);
    wr(UAD_IDX_EVENT_MASK, 8'h08);
    host.send(host.P_HALT, 1'b0);
    `CHK(summary_set, 1'b0)
    host.send(host.P_SHORT, 1'b0);
    `CHK(summary_set, 1'b1)
    wr(UAD_IDX_EVENT_MASK, 8'h02);
  endtask

  // Every legal select code, then a reserved one
  task automatic t_copy;
    for (int k = 0; k < UAD_N_EP; k++)
    begin
      ep_select = 3'(k);
      rd_chk(UAD_IDX_CHAN_COPY, 8'ha1 + 8'(k));
    end
    ep_select = 3'h6;
    rd_chk(UAD_IDX_CHAN_COPY, 8'ha6);
  endtask

  task automatic t_budget;
    dir_rx = 1'b1;
    wr(UAD_IDX_BUDGET, 8'h01);
    auto_active = 1'b1;
    host.send(host.P_TXOK, 1'b0);
    rd_chk(UAD_IDX_BUDGET, 8'h01);
    host.send(host.P_RXOK, 1'b0);
    `CHK(count_exhausted_event, 1'b0)
    rd_chk(UAD_IDX_BUDGET, 8'h00);
    host.send(host.P_RXOK, 1'b0);
    `CHK(count_exhausted_event, 1'b1)
    rd_chk(UAD_IDX_BUDGET, 8'h00);
    // Write and decrement land on the same edge
    fork
      wr(UAD_IDX_BUDGET, 8'h05);
      host.send(host.P_RXOK, 1'b0);
    join
    rd_chk(UAD_IDX_BUDGET, 8'h05);
    // Clock enable low: a completed packet must not move the budget
    ce = 1'b0;
    host.send(host.P_RXOK, 1'b0);
    ce = 1'b1;
    rd_chk(UAD_IDX_BUDGET, 8'h05);
    dir_rx = 1'b0;
    host.send(host.P_TXOK, 1'b0);
    rd_chk(UAD_IDX_BUDGET, 8'h04);
    auto_active = 1'b0;
  endtask

  task automatic t_retry;
    wr(UAD_IDX_RETRY, 8'h82);
    auto_active = 1'b1;
    host.send(host.P_ERR, 1'b0);
    rd_chk(UAD_IDX_RETRY, 8'h81);
    wr(UAD_IDX_RETRY, 8'h05);
    host.send(host.P_OK, 1'b0);
    rd_chk(UAD_IDX_RETRY, 8'h82);
    host.send(host.P_ERR, 1'b0);
    host.send(host.P_ERR, 1'b0);
    `CHK(transfer_fault_event, 1'b0)
    host.send(host.P_ERR, 1'b0);
    `CHK(transfer_fault_event, 1'b1)
    @(negedge ref_clk);
    `CHK(summary_set, 1'b1)
    rd_chk(UAD_IDX_RETRY, 8'h80);
    auto_active = 1'b0;
    rd_chk(UAD_IDX_RETRY, 8'h82);
    wr(UAD_IDX_RETRY, 8'h02);
    auto_active = 1'b1;
    host.send(host.P_ERR, 1'b0);
    rd_chk(UAD_IDX_RETRY, 8'h02);
    auto_active = 1'b0;
  endtask

  // Recovery actions per direction and transfer type
  task automatic t_recover;
    wr(UAD_IDX_RETRY, 8'h83);
    auto_active = 1'b1;
    host.send(host.P_NOACK, 1'b0);
    `CHK(tx_reload, 1'b1)
    dir_rx = 1'b1;
    host.send(host.P_ERR, 1'b0);
    `CHK(rx_flush, 1'b1)
    `CHK(iso_discard, 1'b0)
    iso_mode = 1'b1;
    host.send(host.P_ERR, 1'b0);
    `CHK(iso_discard, 1'b1)
    auto_active = 1'b0;
    iso_mode = 1'b0;
  endtask

  task automatic t_ep0;
    wr(UAD_IDX_EP0_CFG, 8'h00);
    `CHK(use_default_addr, 1'b0)
    wr(UAD_IDX_EP0_CFG, 8'hcf);
    rd_chk(UAD_IDX_EP0_CFG, 8'hc0);
    ep0_tx_fifo_en = 1'b1;
    host.send(host.P_SETUP, 1'b0);
    `CHK(ep0_stall_reply, 1'b0)
    host.send(host.P_OUT, 1'b0);
    `CHK(ep0_stall_reply, 1'b0)
    host.send(host.P_IN, 1'b0);
    `CHK(ep0_stall_reply, 1'b1)
    ep0_rx_fifo_en = 1'b1;
    host.send(host.P_OUT, 1'b0);
    `CHK(ep0_stall_reply, 1'b1)
    host.send(host.P_STALL, 1'b0);
    `CHK(ep0_rx_last_set, 1'b1)
    ep0_free_bytes = 4'h3;
    rd_chk(UAD_IDX_EP0_TXS, 8'h23);
    rd_chk(UAD_IDX_EP0_TXS, 8'h03);
    wr(UAD_IDX_EP0_CFG, 8'h40);
    host.send(host.P_OUT, 1'b0);
    `CHK(use_default_addr, 1'b1)
    host.send(host.P_SENT, 1'b1);
    `CHK(use_default_addr, 1'b0)
    rd_chk(UAD_IDX_EP0_TXS, 8'h63);
    rd_chk(UAD_IDX_EP0_TXS, 8'h03);
    host.send(host.P_SENT, 1'b0);
    ep0_free_bytes = 4'hf;
    rd_chk(UAD_IDX_EP0_TXS, 8'h28);
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn
  initial
  begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_mask;
    t_copy;
    t_budget;
    t_retry;
    t_recover;
    t_ep0;
    test_done;
  end

  // Watchdog well beyond the roughly 140 cycles the scenarios need
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    test_done;
  end
endmodule

// ==== hw/uad_core.sv ====
/*
  Automatic-transfer support and control endpoint logic of a USB node:
  event mask, channel status copy, packet budget, retry handling,
  control endpoint config and transmit status.
  Assumes the serial engine, FIFOs and transfer event register live
  outside and exchange one-cycle pulses on ref_clk.
*/
// Summary of operation
// - Masked events raise the summary flag
// - Status copy shows selected endpoint, resets 1Fh
// - Budget counts down, flags when exhausted
// - Budget steps only after full successful packet
// - Budget write beats simultaneous decrement
// - Retry counter decrements per error with recovery
// - Success or stop restores retry preset
// - Error at zero raises transfer fault
// - Retry writes only when idle; reads mode-dependent
// - Unacked transmit packet reloaded and rescheduled
// - Corrupt received packet flushed for retry
// - Isochronous bad packet dropped, FIFO reset
// - Endpoint number field always reads zero
// - Default address answered until IN sent
// - Address switch right after status stage
// - Stall IN and OUT tokens, never SETUP
// - Sent stall sets receive-last and transmit-done
// - Transmit status resets 08h, free count max 8
// - Ack and done flags clear on status read
// - Endpoint select codes 0..5, 6..7 reserved
`timescale 1ns/1ps
module uad_core
  import uad_pkg::*;
#(
  parameter int BUDGET_W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [UAD_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic auto_active,
  input wire logic [2:0] ep_select,
  input wire logic dir_rx,
  input wire logic iso_mode,
  input wire logic [UAD_N_EP*8-1:0] ep_status,
  input wire logic halt_event,
  input wire logic short_event,
  input wire logic rx_stored_ok,
  input wire logic tx_sent_ok,
  input wire logic bus_err,
  input wire logic txn_ok,
  input wire logic tx_no_ack,
  input wire logic ep0_in_token,
  input wire logic ep0_out_token,
  input wire logic ep0_setup_token,
  input wire logic ep0_tx_fifo_en,
  input wire logic ep0_rx_fifo_en,
  input wire logic ep0_in_sent,
  input wire logic ep0_stall_sent,
  input wire logic ep0_host_ack,
  input wire logic [3:0] ep0_free_bytes,
  output logic summary_set,
  output logic count_exhausted_event,
  output logic transfer_fault_event,
  output logic tx_reload,
  output logic rx_flush,
  output logic iso_discard,
  output logic ep0_stall_reply,
  output logic ep0_rx_last_set,
  output logic use_default_addr
);

  logic [UAD_EV_N-1:0] mask_reg;
  logic [UAD_EV_N-1:0] mask_next;
  logic [7:0] copy_reg;
  logic [7:0] copy_next;
  logic stall_reg;
  logic stall_next;
  logic defaddr_reg;
  logic defaddr_next;
  logic ack_reg;
  logic ack_next;
  logic done_reg;
  logic done_next;
  logic [3:0] free_reg;
  logic [3:0] free_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [UAD_EV_N-1:0] ev_vec;
  logic [UAD_N_EP-1:0][7:0] status_arr;
  logic [BUDGET_W-1:0] budget_count;
  logic [UAD_RETRY_CNT_W-1:0] retry_preset;
  logic [UAD_RETRY_CNT_W-1:0] retry_count;
  logic aer_reg;
  logic aer_next;
  logic op_done;
  logic exh_pulse;
  logic fault_pulse;
  logic sel_ok;
  logic wr_mask;
  logic wr_budget;
  logic wr_retry;
  logic wr_cfg;
  logic rd_txs;
  logic sum_reg;
  logic sum_next;
  logic [2:0] recov_reg;
  logic [2:0] recov_next;
  logic stall_rep_reg;
  logic stall_rep_next;
  logic rxlast_reg;
  logic rxlast_next;

  // Write and read strobes per register
  assign wr_mask = reg_wr && reg_addr == UAD_IDX_EVENT_MASK;
  assign wr_budget = reg_wr && reg_addr == UAD_IDX_BUDGET;
  assign wr_retry = reg_wr && reg_addr == UAD_IDX_RETRY;
  assign wr_cfg = reg_wr && reg_addr == UAD_IDX_EP0_CFG;
  assign rd_txs = reg_rd && reg_addr == UAD_IDX_EP0_TXS;

  // Unpack per-endpoint status words
  genvar gi;
  generate
    for (gi = 0; gi < UAD_N_EP; gi++)
    begin : g_status
      assign status_arr[gi] = ep_status[gi*8 +: 8];
    end
  endgenerate

  // Reserved select codes leave the copy unchanged
  assign sel_ok = ep_select <= UAD_SEL_LAST;

  // Budget steps only on a fully completed packet in its direction
  assign op_done = auto_active && (dir_rx ? rx_stored_ok : tx_sent_ok);

  uad_packet_budget #(
    .W(BUDGET_W)
  ) u_budget (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_budget),
    .wr_data(reg_wdata[BUDGET_W-1:0]),
    .op_done(op_done),
    .count(budget_count),
    .exhausted(exh_pulse)
  );

  uad_retry_counter #(
    .W(UAD_RETRY_CNT_W)
  ) u_retry (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .auto_active(auto_active),
    .aer(aer_reg),
    .preset_wr(wr_retry),
    .preset_data(reg_wdata[UAD_RETRY_CNT_W-1:0]),
    .bus_err(bus_err),
    .txn_ok(txn_ok),
    .preset(retry_preset),
    .count(retry_count),
    .fault(fault_pulse)
  );

  // Events presented in transfer event register order
  always_comb
  begin
    ev_vec = '0;
    ev_vec[UAD_EV_HALT] = halt_event;
    ev_vec[UAD_EV_FAULT] = fault_pulse;
    ev_vec[UAD_EV_COUNT] = exh_pulse;
    ev_vec[UAD_EV_SHORT] = short_event;
  end

  // Configuration, status and recovery next-state logic
  always_comb
  begin
    mask_next = mask_reg;
    aer_next = aer_reg;
    copy_next = copy_reg;
    stall_next = stall_reg;
    defaddr_next = defaddr_reg;
    ack_next = ack_reg;
    done_next = done_reg;
    free_next = free_reg;
    if (wr_mask)
    begin
      mask_next = reg_wdata[UAD_EV_N-1:0];
    end
    // Recovery bit shares the retry register's write lock
    if (wr_retry && !auto_active)
    begin
      aer_next = reg_wdata[UAD_RETRY_AER_BIT];
    end
    if (sel_ok)
    begin
      copy_next = status_arr[ep_select];
    end
    if (wr_cfg)
    begin
      stall_next = reg_wdata[UAD_CFG_STALL_BIT];
      defaddr_next = reg_wdata[UAD_CFG_DEFADDR_BIT];
    end
    // Clearing on the IN that ends the status stage swaps address now
    if (ep0_in_sent)
    begin
      defaddr_next = 1'b0;
    end
    // Read clears first, so a same-cycle completion still lands
    if (rd_txs)
    begin
      ack_next = 1'b0;
      done_next = 1'b0;
    end
    if (ep0_in_sent || ep0_stall_sent)
    begin
      done_next = 1'b1;
      ack_next = ep0_in_sent && ep0_host_ack;
    end
    // Clamp guards against a miscounting FIFO
    free_next = (ep0_free_bytes > UAD_EP0_FIFO_BYTES) ?
      UAD_EP0_FIFO_BYTES : ep0_free_bytes;
  end

  // Pulse outputs toward the event register and the link engine
  always_comb
  begin
    sum_next = |(ev_vec & mask_reg);
    recov_next = '0;
    if (auto_active && aer_reg && !iso_mode && !dir_rx && tx_no_ack)
    begin
      recov_next[0] = 1'b1;
    end
    if (auto_active && aer_reg && !iso_mode && dir_rx && bus_err)
    begin
      recov_next[1] = 1'b1;
    end
    if (auto_active && aer_reg && iso_mode && dir_rx && bus_err)
    begin
      recov_next[2] = 1'b1;
    end
    // A SETUP token is never stalled
    stall_rep_next = stall_reg && !ep0_setup_token &&
      ((ep0_in_token && ep0_tx_fifo_en) ||
       (ep0_out_token && ep0_rx_fifo_en));
    rxlast_next = ep0_stall_sent;
  end

  // Read data mux; endpoint number always reads as zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      unique case (reg_addr)
        UAD_IDX_EVENT_MASK: rdata_next = {4'h0, mask_reg};
        UAD_IDX_CHAN_COPY: rdata_next = copy_reg;
        UAD_IDX_BUDGET: rdata_next = 8'(budget_count);
        UAD_IDX_RETRY: rdata_next = {aer_reg,
          auto_active ? retry_count : retry_preset};
        UAD_IDX_EP0_CFG: rdata_next = {stall_reg, defaddr_reg, 2'h0,
          UAD_EP0_NUMBER};
        UAD_IDX_EP0_TXS: rdata_next = {1'b0, ack_reg, done_reg, 1'b0,
          free_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mask_reg <= UAD_RST_EVENT_MASK[UAD_EV_N-1:0];
      aer_reg <= UAD_RST_RETRY[UAD_RETRY_AER_BIT];
      copy_reg <= UAD_RST_CHAN_COPY;
      stall_reg <= UAD_RST_EP0_CFG[UAD_CFG_STALL_BIT];
      defaddr_reg <= UAD_RST_EP0_CFG[UAD_CFG_DEFADDR_BIT];
      ack_reg <= 1'b0;
      done_reg <= 1'b0;
      free_reg <= UAD_RST_FREE_COUNT;
      rdata_reg <= 8'h00;
      sum_reg <= 1'b0;
      recov_reg <= '0;
      stall_rep_reg <= 1'b0;
      rxlast_reg <= 1'b0;
    end
    else if (ce)
    begin
      mask_reg <= mask_next;
      aer_reg <= aer_next;
      copy_reg <= copy_next;
      stall_reg <= stall_next;
      defaddr_reg <= defaddr_next;
      ack_reg <= ack_next;
      done_reg <= done_next;
      free_reg <= free_next;
      rdata_reg <= rdata_next;
      sum_reg <= sum_next;
      recov_reg <= recov_next;
      stall_rep_reg <= stall_rep_next;
      rxlast_reg <= rxlast_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign summary_set = sum_reg;
  assign count_exhausted_event = exh_pulse;
  assign transfer_fault_event = fault_pulse;
  assign tx_reload = recov_reg[0];
  assign rx_flush = recov_reg[1];
  assign iso_discard = recov_reg[2];
  assign ep0_stall_reply = stall_rep_reg;
  assign ep0_rx_last_set = rxlast_reg;
  assign use_default_addr = defaddr_reg;

  AST_SUMMARY_MASK: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> sum_reg == |($past(ev_vec) & $past(mask_reg)))
    else $error("summary flag disagrees with masked events");
  AST_COPY_TRACKS: assert property (@(posedge ref_clk) disable iff (rst)
    ce && sel_ok |=> copy_reg == $past(status_arr[ep_select]))
    else $error("status copy not following select");
  AST_EP_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    ce && reg_rd && reg_addr == UAD_IDX_EP0_CFG |=> rdata_reg[3:0] == 4'h0)
    else $error("endpoint number field not zero");
  AST_DEFADDR_CLR: assert property (@(posedge ref_clk) disable iff (rst)
    ce && ep0_in_sent |=> !defaddr_reg)
    else $error("default address kept after IN");
  AST_SETUP_NOSTALL: assert property (@(posedge ref_clk) disable iff (rst)
    ce && ep0_setup_token |=> !stall_rep_reg)
    else $error("SETUP token stalled");
  AST_STALL_FLAGS: assert property (@(posedge ref_clk) disable iff (rst)
    ce && ep0_stall_sent |=> done_reg && rxlast_reg)
    else $error("stall did not set completion flags");
  AST_FREE_MAX: assert property (@(posedge ref_clk) disable iff (rst)
    free_reg <= UAD_EP0_FIFO_BYTES)
    else $error("free byte count above FIFO size");
  AST_TXS_RDCLR: assert property (@(posedge ref_clk) disable iff (rst)
    ce && rd_txs && !ep0_in_sent && !ep0_stall_sent |=> !done_reg && !ack_reg)
    else $error("transmit flags survived status read");

  COV_BUDGET_EXH: cover property (@(posedge ref_clk) disable iff (rst)
    exh_pulse);
  COV_RETRY_FAULT: cover property (@(posedge ref_clk) disable iff (rst)
    fault_pulse && summary_set == 1'b0);
  COV_STALL: cover property (@(posedge ref_clk) disable iff (rst)
    stall_rep_reg);
  COV_ADDR_SWAP: cover property (@(posedge ref_clk) disable iff (rst)
    defaddr_reg ##1 !defaddr_reg);

endmodule

// ==== hw/uad_packet_budget.sv ====
/*
  Packet budget counter for automatic transfers.
  Assumes the caller pulses op_done only for fully successful operations.
*/
`timescale 1ns/1ps
module uad_packet_budget
  import uad_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic op_done,
  output logic [W-1:0] count,
  output logic exhausted
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic exh_reg;
  logic exh_next;

  // Software write beats the decrement; zero holds and flags instead
  always_comb
  begin
    count_next = count_reg;
    exh_next = 1'b0;
    if (wr_en)
    begin
      count_next = wr_data;
    end
    else if (op_done)
    begin
      if (count_reg != '0)
      begin
        count_next = count_reg - 1'b1;
      end
      else
      begin
        exh_next = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_reg <= W'(UAD_RST_BUDGET);
      exh_reg <= 1'b0;
    end
    else if (ce)
    begin
      count_reg <= count_next;
      exh_reg <= exh_next;
    end
  end

  assign count = count_reg;
  assign exhausted = exh_reg;

  AST_BUDGET_NO_UNDERFLOW: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !wr_en && op_done && count_reg == '0 |=> count_reg == '0 && exh_reg)
    else $error("budget wrapped or missed exhausted flag");
  AST_BUDGET_WRITE_WINS: assert property (@(posedge ref_clk) disable iff (rst)
    ce && wr_en |=> count_reg == $past(wr_data))
    else $error("budget write lost to decrement");
  AST_BUDGET_DEC: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !wr_en && op_done && count_reg != '0
    |=> count_reg == $past(count_reg) - 1'b1 && !exh_reg)
    else $error("budget did not step down by one");

endmodule

// ==== hw/uad_pkg.sv ====
/*
  Shared constants for the automatic-transfer support logic and the
  control endpoint of the USB function node.
  Assumes a single CPU clock domain and a byte-wide register port.
*/
package uad_pkg;

  // Register port width and register indices
  localparam int UAD_ADDR_W = 3;
  localparam logic [2:0] UAD_IDX_EVENT_MASK = 3'h0;
  localparam logic [2:0] UAD_IDX_CHAN_COPY = 3'h1;
  localparam logic [2:0] UAD_IDX_BUDGET = 3'h2;
  localparam logic [2:0] UAD_IDX_RETRY = 3'h3;
  localparam logic [2:0] UAD_IDX_EP0_CFG = 3'h4;
  localparam logic [2:0] UAD_IDX_EP0_TXS = 3'h5;

  // Reset values
  localparam logic [7:0] UAD_RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] UAD_RST_CHAN_COPY = 8'h1F;
  localparam logic [7:0] UAD_RST_BUDGET = 8'h00;
  localparam logic [7:0] UAD_RST_RETRY = 8'h00;
  localparam logic [7:0] UAD_RST_EP0_CFG = 8'h00;
  localparam logic [3:0] UAD_RST_FREE_COUNT = 4'h8;

  // Event bit positions (bits 0 to 3 of the transfer event register)
  localparam int UAD_EV_HALT = 0;
  localparam int UAD_EV_FAULT = 1;
  localparam int UAD_EV_COUNT = 2;
  localparam int UAD_EV_SHORT = 3;
  localparam int UAD_EV_N = 4;

  // Retry control register fields
  localparam int UAD_RETRY_AER_BIT = 7;
  localparam int UAD_RETRY_CNT_W = 7;

  // Control endpoint config fields
  localparam int UAD_CFG_STALL_BIT = 7;
  localparam int UAD_CFG_DEFADDR_BIT = 6;
  localparam logic [3:0] UAD_EP0_NUMBER = 4'h0;

  // Control endpoint transmit status fields
  localparam int UAD_TXS_ACK_BIT = 6;
  localparam int UAD_TXS_DONE_BIT = 5;
  localparam logic [3:0] UAD_EP0_FIFO_BYTES = 4'h8;

  // Transfer endpoint select: codes 0..5 map to endpoints 1..6
  localparam logic [2:0] UAD_SEL_LAST = 3'h5;
  localparam int UAD_N_EP = 6;

endpackage

// ==== hw/uad_retry_counter.sv ====
/*
  Consecutive-error retry counter with software preset.
  Assumes bus_err and txn_ok are one-cycle pulses from the link logic.
*/
`timescale 1ns/1ps
module uad_retry_counter
  import uad_pkg::*;
#(
  parameter int W = UAD_RETRY_CNT_W
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic auto_active,
  input wire logic aer,
  input wire logic preset_wr,
  input wire logic [W-1:0] preset_data,
  input wire logic bus_err,
  input wire logic txn_ok,
  output logic [W-1:0] preset,
  output logic [W-1:0] count,
  output logic fault
);

  logic [W-1:0] preset_reg;
  logic [W-1:0] preset_next;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic fault_reg;
  logic fault_next;

  // Counter tracks the preset whenever auto mode is idle
  always_comb
  begin
    preset_next = preset_reg;
    cnt_next = cnt_reg;
    fault_next = 1'b0;
    if (preset_wr && !auto_active)
    begin
      preset_next = preset_data;
    end
    // Take the incoming preset too, so a start right after a write
    // counts down from the new value rather than a stale one
    if (!auto_active || txn_ok)
    begin
      cnt_next = preset_next;
    end
    else if (bus_err && aer)
    begin
      if (cnt_reg != '0)
      begin
        cnt_next = cnt_reg - 1'b1;
      end
      else
      begin
        fault_next = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      preset_reg <= W'(UAD_RST_RETRY);
      cnt_reg <= W'(UAD_RST_RETRY);
      fault_reg <= 1'b0;
    end
    else if (ce)
    begin
      preset_reg <= preset_next;
      cnt_reg <= cnt_next;
      fault_reg <= fault_next;
    end
  end

  assign preset = preset_reg;
  assign count = cnt_reg;
  assign fault = fault_reg;

  AST_RETRY_DEC: assert property (@(posedge ref_clk) disable iff (rst)
    ce && auto_active && aer && bus_err && !txn_ok && cnt_reg != '0
    |=> cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("retry counter did not decrement");
  AST_RETRY_NO_AER: assert property (@(posedge ref_clk) disable iff (rst)
    ce && auto_active && !aer && !txn_ok |=> $stable(cnt_reg))
    else $error("retry counter moved without recovery");
  AST_RETRY_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    ce && (txn_ok || !auto_active) |=> cnt_reg == preset_reg)
    else $error("retry counter not restored to preset");
  AST_RETRY_FAULT: assert property (@(posedge ref_clk) disable iff (rst)
    ce && auto_active && aer && bus_err && !txn_ok && cnt_reg == '0
    |=> fault_reg && cnt_reg == '0)
    else $error("retry fault missing or counter wrapped");
  AST_RETRY_WR_LOCK: assert property (@(posedge ref_clk) disable iff (rst)
    ce && auto_active |=> $stable(preset_reg))
    else $error("preset changed while auto mode active");

endmodule
